// ---- bench/tdo_alu_model.sv ----
// alu stand-in: answers each start after a fixed delay
// assumes start and index arrive on the same clock
`timescale 1ns/1ps
module tdo_alu_model #(
   parameter int DLY = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // request and answer
   input wire logic alu_start,
   input wire logic [11:0] alu_index,
   output logic alu_done,
   output logic [11:0] alu_result0,
   output logic [11:0] alu_result1
);
   int cnt;
   logic [11:0] idx;
   // results hold between answers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         idx <= 12'h000;
         alu_done <= 1'b0;
         alu_result0 <= 12'h000;
         alu_result1 <= 12'h000;
      end else begin
         alu_done <= 1'b0;
         if (alu_start) begin
            idx <= alu_index;
            cnt <= DLY;
         end else if (cnt == 1) begin
            alu_done <= 1'b1;
            alu_result0 <= idx + 12'h011;
            alu_result1 <= ~idx;
            cnt <= 0;
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule : tdo_alu_model

// ---- bench/tdo_path_ctrl_tb_top.sv ----
// self-checking bench for tdo_path_ctrl with an alu stand-in
// assumes the checker and alu model files are compiled with it
`timescale 1ns/1ps
module tdo_path_ctrl_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] sensor_sample = 12'h000;
   logic sensor_sample_valid = 1'b0;
   logic sensor_ready = 1'b0;
   logic [1:0] nvm_skip_flag = 2'b01;
   logic [11:0] nvm_constant0 = 12'h6B2;
   logic [11:0] nvm_constant1 = 12'h3C7;
   logic [7:0] reg_rdata;
   logic reg_rvalid, alu_start, alu_done, privilege_level_two;
   logic [11:0] alu_index, alu_result0, alu_result1, dac0_word, dac1_word;
   logic [11:0] rb;
   int n_errors = 0;
   int checks_done = 0;
   tdo_path_ctrl #(.W(12)) dut_u (.clk(clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sensor_sample(sensor_sample), .sensor_ready(sensor_ready),
      .sensor_sample_valid(sensor_sample_valid),
      .nvm_skip_flag(nvm_skip_flag), .nvm_constant0(nvm_constant0),
      .nvm_constant1(nvm_constant1), .alu_start(alu_start),
      .alu_index(alu_index), .alu_done(alu_done),
      .alu_result0(alu_result0), .alu_result1(alu_result1),
      .dac0_word(dac0_word), .dac1_word(dac1_word),
      .privilege_level_two(privilege_level_two));
   tdo_alu_model #(.DLY(3)) alu_u (.clk(clk), .nrst(nrst),
      .alu_start(alu_start), .alu_index(alu_index), .alu_done(alu_done),
      .alu_result0(alu_result0), .alu_result1(alu_result1));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ------
   // shared tasks
   // ------
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [11:0] seen,
         input logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   // key pair on consecutive edges, strobe held between them
   task automatic key(input logic [7:0] d1, input logic [7:0] d2);
      @(negedge clk);
      reg_addr = 8'h0F;
      reg_wdata = d1;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wdata = d2;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : key
   task automatic rd(input logic [7:0] a);
      int i;
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
      check("read answer", {11'h0, reg_rvalid}, 12'h001);
      if (reg_rvalid !== 1'b1) tally_and_finish();
      rb = {4'h0, reg_rdata};
   endtask : rd
   // sample line changes after the pulse
   task automatic sample(input logic [11:0] v);
      int i;
      @(negedge clk);
      sensor_sample = v;
      sensor_sample_valid = 1'b1;
      @(negedge clk);
      sensor_sample_valid = 1'b0;
      sensor_sample = ~v;
      for (i = 0; i < 20 && alu_done !== 1'b1; i++) @(negedge clk);
      check("alu answer", {11'h0, alu_done}, 12'h001);
      if (alu_done !== 1'b1) tally_and_finish();
      repeat (2) @(negedge clk);
   endtask : sample
   // ------
   // scenarios
   // ------
   task automatic t_power_up;
      repeat (2) @(negedge clk);
      check("dac0 bypass", dac0_word, 12'h6B2);
      check("dac1 plain", dac1_word, 12'h000);
      rd(8'h08);
      check("select reset", rb, 12'h000);
      rd(8'h0C);
      check("override reset", rb, 12'h000);
      rd(8'h0F);
      check("level zero", rb, 12'h000);
      rd(8'h06);
      check("unmapped read", rb, 12'h000);
      rd(8'h07);
      check("status busy", rb, 12'h0FF);
      $display("test power_up done");
   endtask : t_power_up
   task automatic t_readout;
      sensor_ready = 1'b1;
      sample(12'hA5C);
      check("dac1 computed", dac1_word, 12'h5A3);
      check("dac0 fixed", dac0_word, 12'h6B2);
      rd(8'h05);
      check("dac1 readback", rb, 12'h0A3);
      rd(8'h07);
      check("status ready", rb, 12'h000);
      rd(8'h00);
      check("upper sample", rb & 12'h06F, 12'h00A);
      sample(12'h123);
      rd(8'h01);
      check("frozen lower", rb, 12'h05C);
      rd(8'h00);
      check("new upper", rb & 12'h06F, 12'h001);
      wr(8'h01, 8'hFF);
      rd(8'h01);
      check("lower read-only", rb, 12'h023);
      $display("test readout done");
   endtask : t_readout
   task automatic t_lock;
      wr(8'h0B, 8'h08);
      wr(8'h0C, 8'h00);
      wr(8'h08, 8'h02);
      rd(8'h08);
      check("locked select", rb, 12'h000);
      check("locked dac0", dac0_word, 12'h6B2);
      key(8'hCD, 8'h11);
      wr(8'h0F, 8'hF0);
      rd(8'h0F);
      check("broken key", rb, 12'h000);
      key(8'hCD, 8'hF0);
      check("unlocked", {11'h0, privilege_level_two}, 12'h001);
      rd(8'h0F);
      check("level two", rb, 12'h003);
      $display("test lock done");
   endtask : t_lock
   task automatic t_override;
      wr(8'h0B, 8'h08);
      wr(8'h0D, 8'h04);
      rd(8'h0B);
      check("upper pending", rb, 12'h000);
      wr(8'h0C, 8'h00);
      rd(8'h0B);
      check("upper committed", rb, 12'h008);
      wr(8'h0E, 8'h00);
      wr(8'h08, 8'h02);
      repeat (2) @(negedge clk);
      check("dac0 override", dac0_word, 12'h800);
      check("dac1 override", dac1_word, 12'h400);
      wr(8'h0B, 8'h0F);
      repeat (2) @(negedge clk);
      check("upper alone", dac0_word, 12'h800);
      wr(8'h0C, 8'h3C);
      repeat (2) @(negedge clk);
      check("pair commit", dac0_word, 12'hF3C);
      sample(12'h0F0);
      check("alu ignored", dac1_word, 12'h400);
      $display("test override done");
   endtask : t_override
   task automatic t_sensor_override;
      wr(8'h08, 8'h00);
      repeat (2) @(negedge clk);
      check("bypass back", dac0_word, 12'h6B2);
      wr(8'h09, 8'h01);
      wr(8'h0A, 8'h01);
      wr(8'h08, 8'h01);
      sample(12'h777);
      check("override index", alu_index, 12'h101);
      check("indexed word", dac1_word, 12'hEFE);
      wr(8'h08, 8'h00);
      sample(12'h222);
      check("sensor index", alu_index, 12'h222);
      wr(8'h0F, 8'h00);
      check("relocked", {11'h0, privilege_level_two}, 12'h000);
      $display("test sensor_override done");
   endtask : t_sensor_override
   initial begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_power_up();
      t_readout();
      t_lock();
      t_override();
      t_sensor_override();
      tally_and_finish();
   end
endmodule : tdo_path_ctrl_tb_top
bind tdo_path_ctrl tdo_path_properties #(.W(W)) chk_u (.clk(clk),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .sensor_sample(sensor_sample),
   .sensor_sample_valid(sensor_sample_valid),
   .nvm_skip_flag(nvm_skip_flag), .nvm_constant0(nvm_constant0),
   .alu_start(alu_start), .alu_index(alu_index), .alu_done(alu_done),
   .alu_result1(alu_result1), .dac0_word(dac0_word),
   .dac1_word(dac1_word), .privilege_level_two(privilege_level_two));

// ---- bench/tdo_path_properties.sv ----
// checker: read answers, keys and data paths of tdo_path_ctrl
// assumes a bind into tdo_path_ctrl; sees its ports only
`timescale 1ns/1ps
module tdo_path_properties #(
   parameter int unsigned W = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // sensor, memory image, arithmetic unit
   input wire logic [W-1:0] sensor_sample,
   input wire logic sensor_sample_valid,
   input wire logic [1:0] nvm_skip_flag,
   input wire logic [W-1:0] nvm_constant0,
   input wire logic alu_start,
   input wire logic [W-1:0] alu_index,
   input wire logic alu_done,
   input wire logic [W-1:0] alu_result1,
   // converter words and mode
   input wire logic [W-1:0] dac0_word,
   input wire logic [W-1:0] dac1_word,
   input wire logic privilege_level_two
);
   // ------
   // select shadow, cycles since release
   // ------
   logic [1:0] sel;
   logic [1:0] age;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) sel <= 2'h0;
      else if (privilege_level_two && reg_wr && reg_addr == 8'h08)
         sel <= reg_wdata[1:0];
   end
   // image copy takes an edge: bypass shows from the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence key_first;
      reg_wr && reg_addr == 8'h0F && reg_wdata == 8'hCD;
   endsequence
   sequence key_pair;
      key_first ##1 (reg_wr && reg_addr == 8'h0F && reg_wdata == 8'hF0);
   endsequence
   // ------
   // properties
   // ------
   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read got no answer");
   chk_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("answer without a read");
   chk_key_unlock: assert property (key_pair |=> privilege_level_two)
      else $error("key pair did not unlock");
   chk_level_read: assert property (
      reg_rd && reg_addr == 8'h0F && privilege_level_two
      |=> reg_rdata == 8'h03) else $error("level two reads wrong");
   chk_upper_zero: assert property (
      reg_rd && reg_addr == 8'h00 |=> reg_rdata[6:5] == 2'h0)
      else $error("upper sample bits 6:5 not zero");
   chk_alu_kick: assert property (sensor_sample_valid |=> alu_start)
      else $error("sample did not start the alu");
   chk_sensor_index: assert property (
      sensor_sample_valid && !sel[0] |=> alu_index == $past(sensor_sample))
      else $error("alu index not the sample");
   chk_bypass_const: assert property (
      age >= 2'h2 && nvm_skip_flag[0] && !$past(sel[1])
      |-> dac0_word == nvm_constant0) else $error("bypass word wrong");
   chk_computed_word: assert property (
      alu_done && !nvm_skip_flag[1] && !sel[1]
      |=> ##1 dac1_word == $past(alu_result1, 2))
      else $error("computed word lost");
endmodule : tdo_path_properties

// ---- verilog/tdo_chan_path.sv ----
// one output channel: selects the word presented to its converter
// assumes select and data inputs come from logic on the same clock
`timescale 1ns/1ps
module tdo_chan_path #(
   parameter int unsigned W = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // sources
   input wire logic alu_skip_flag,
   input wire logic [W-1:0] stored_constant_level,
   input wire logic [W-1:0] computed_word,
   input wire logic [W-1:0] override_word,
   input wire logic converter_override_select,
   // converter input
   output logic [W-1:0] dac_word
);

   // ------
   // output mux
   // ------
   // host override sits nearest the converter, so it beats the bypass
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac_word <= '0;
      end else if (converter_override_select) begin
         dac_word <= override_word;
      end else if (alu_skip_flag) begin
         dac_word <= stored_constant_level;
      end else begin
         dac_word <= computed_word;
      end
   end

endmodule : tdo_chan_path

// ---- verilog/tdo_path_ctrl.sv ----
// signal-path control: bypass, override registers, coherent sample readout
// assumes a byte register port driven by a serial-link engine on clk,
// a sensor and arithmetic unit on clk, and memory image valid at reset
//
// Behaviour
// - override registers volatile, cleared at power up
// - bypass flags copied from memory at power up
// - set bypass drives constant level at once
// - bypass routes stored constant, ignores computed word; here a converter override select still wins over the bypass
// - each channel own bypass flag and constant
// - override word is upper nibble plus byte
// - one override select serves both channels
// - upper override write commits on lower write
// - keys 0xCD then 0xF0 unlock level two
// - access register reads 0x03 at level two
// - select value 0x02 routes override to converters
// - override word is offset binary, passed unchanged
// - new 12-bit sample held in two registers
// - upper sample read freezes lower byte
// - upper sample bits 6:5 read zero
// - lower sample read-only, sample bits 7:0
// - select bit 1 converter, bit 0 sensor
// - sensor override commits on lower write
// - each new sample restarts computation
`timescale 1ns/1ps
module tdo_path_ctrl #(
   parameter int unsigned W = tdo_pkg::WORD_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port from the link engine
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // temperature sensor
   input wire logic [W-1:0] sensor_sample,
   input wire logic sensor_sample_valid,
   input wire logic sensor_ready,
   // nonvolatile image, stable from reset release
   input wire logic [1:0] nvm_skip_flag,
   input wire logic [W-1:0] nvm_constant0,
   input wire logic [W-1:0] nvm_constant1,
   // arithmetic unit
   output logic alu_start,
   output logic [W-1:0] alu_index,
   input wire logic alu_done,
   input wire logic [W-1:0] alu_result0,
   input wire logic [W-1:0] alu_result1,
   // converter inputs
   output logic [W-1:0] dac0_word,
   output logic [W-1:0] dac1_word,
   // mode status
   output logic privilege_level_two
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // upper register view: nibble in the low bits, zeros above
   function automatic logic [7:0] upper_view(input logic [W-1:0] w);
      upper_view = {4'h0, w[W-1:8]};
   endfunction : upper_view

   function automatic logic [7:0] lower_view(input logic [W-1:0] w);
      lower_view = w[7:0];
   endfunction : lower_view

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [W-1:0] temp_sample;
   logic [7:0] temp_sample_lower;
   logic seen_sample;
   logic [1:0] override_select_reg;
   logic [3:0] sensor_override_pending;
   logic [W-1:0] sensor_override_word;
   logic [3:0] dac0_override_pending, dac1_override_pending;
   logic [W-1:0] dac0_override_word, dac1_override_word;
   logic [W-1:0] dac0_computed, dac1_computed;
   logic [1:0] alu_skip_flag;
   logic [W-1:0] stored_constant_level0, stored_constant_level1;
   logic nvm_loaded;
   tdo_pkg::tdo_acc_t acc_state, next_acc_state;
   logic wr_access, wr_allowed;
   logic sensor_override_select, converter_override_select;
   logic [7:0] next_rdata;

   assign wr_access = reg_wr && (reg_addr == tdo_pkg::ADDR_ACCESS_CTRL);
   assign privilege_level_two = (acc_state == tdo_pkg::TDO_ACC_TWO);
   assign wr_allowed = reg_wr && privilege_level_two;
   assign sensor_override_select =
      override_select_reg[tdo_pkg::SEL_SENSOR_BIT];
   assign converter_override_select =
      override_select_reg[tdo_pkg::SEL_DAC_BIT];

   // ------------------------------------------------------------------
   // access level
   // ------------------------------------------------------------------
   // an access-register write other than the next key drops back to level zero; 0xCD always leads to keyed
   always_comb begin
      next_acc_state = acc_state;
      if (wr_access) begin
         case (acc_state)
            tdo_pkg::TDO_ACC_ZERO: begin
               if (reg_wdata == tdo_pkg::KEY_FIRST) begin
                  next_acc_state = tdo_pkg::TDO_ACC_KEYED;
               end
            end
            tdo_pkg::TDO_ACC_KEYED: begin
               if (reg_wdata == tdo_pkg::KEY_SECOND) begin
                  next_acc_state = tdo_pkg::TDO_ACC_TWO;
               end else if (reg_wdata != tdo_pkg::KEY_FIRST) begin
                  next_acc_state = tdo_pkg::TDO_ACC_ZERO;
               end
            end
            tdo_pkg::TDO_ACC_TWO: begin
               if (reg_wdata == tdo_pkg::KEY_FIRST) begin
                  next_acc_state = tdo_pkg::TDO_ACC_KEYED;
               end else begin
                  next_acc_state = tdo_pkg::TDO_ACC_ZERO;
               end
            end
            default: begin
               next_acc_state = tdo_pkg::TDO_ACC_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_state <= tdo_pkg::TDO_ACC_ZERO;
      end else begin
         acc_state <= next_acc_state;
      end
   end

   // ------------------------------------------------------------------
   // override select and override data
   // ------------------------------------------------------------------
   // all of these are volatile: plain reset to zero, never reloaded
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         override_select_reg <= tdo_pkg::SEL_RESET;
      end else if (wr_allowed &&
                   reg_addr == tdo_pkg::ADDR_OVR_SELECT) begin
         // reserved bits dropped; the host keeps to 0, 1 or 2
         override_select_reg <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sensor_override_pending <= tdo_pkg::NIB_RESET;
         sensor_override_word <= tdo_pkg::WORD_RESET;
      end else if (wr_allowed) begin
         if (reg_addr == tdo_pkg::ADDR_SENS_OVR_UPPER) begin
            sensor_override_pending <= reg_wdata[3:0];
         end else if (reg_addr == tdo_pkg::ADDR_SENS_OVR_LOWER) begin
            sensor_override_word <=
               {sensor_override_pending, reg_wdata};
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac0_override_pending <= tdo_pkg::NIB_RESET;
         dac0_override_word <= tdo_pkg::WORD_RESET;
      end else if (wr_allowed) begin
         if (reg_addr == tdo_pkg::ADDR_DAC0_OVR_UPPER) begin
            dac0_override_pending <= reg_wdata[3:0];
         end else if (reg_addr == tdo_pkg::ADDR_DAC0_OVR_LOWER) begin
            dac0_override_word <=
               {dac0_override_pending, reg_wdata};
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac1_override_pending <= tdo_pkg::NIB_RESET;
         dac1_override_word <= tdo_pkg::WORD_RESET;
      end else if (wr_allowed) begin
         if (reg_addr == tdo_pkg::ADDR_DAC1_OVR_UPPER) begin
            dac1_override_pending <= reg_wdata[3:0];
         end else if (reg_addr == tdo_pkg::ADDR_DAC1_OVR_LOWER) begin
            dac1_override_word <=
               {dac1_override_pending, reg_wdata};
         end
      end
   end

   // ------------------------------------------------------------------
   // bypass image load
   // ------------------------------------------------------------------
   // copied on the first edge after release; the image must be stable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nvm_loaded <= 1'b0;
         alu_skip_flag <= 2'h0;
         stored_constant_level0 <= tdo_pkg::WORD_RESET;
         stored_constant_level1 <= tdo_pkg::WORD_RESET;
      end else if (!nvm_loaded) begin
         nvm_loaded <= 1'b1;
         alu_skip_flag <= nvm_skip_flag;
         stored_constant_level0 <= nvm_constant0;
         stored_constant_level1 <= nvm_constant1;
      end
   end

   // ------------------------------------------------------------------
   // temperature sample and computation trigger
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         temp_sample <= tdo_pkg::WORD_RESET;
         seen_sample <= 1'b0;
      end else if (sensor_sample_valid) begin
         temp_sample <= sensor_sample;
         seen_sample <= 1'b1;
      end
   end

   // the override index replaces the sensor at the table input
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alu_start <= 1'b0;
         alu_index <= tdo_pkg::WORD_RESET;
      end else begin
         alu_start <= sensor_sample_valid;
         if (sensor_sample_valid) begin
            alu_index <= sensor_override_select ?
                         sensor_override_word : sensor_sample;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac0_computed <= tdo_pkg::WORD_RESET;
         dac1_computed <= tdo_pkg::WORD_RESET;
      end else if (alu_done) begin
         dac0_computed <= alu_result0;
         dac1_computed <= alu_result1;
      end
   end

   // ------------------------------------------------------------------
   // coherent readout
   // ------------------------------------------------------------------
   // an upper read and a new sample in one cycle: the read sees the old
   // sample and freezes the old low byte, so the pair still matches
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         temp_sample_lower <= tdo_pkg::BYTE_RESET;
      end else if (reg_rd && reg_addr == tdo_pkg::ADDR_TEMP_UPPER) begin
         temp_sample_lower <= lower_view(temp_sample);
      end
   end

   always_comb begin
      next_rdata = tdo_pkg::UNMAPPED_DATA;
      case (reg_addr)
         tdo_pkg::ADDR_TEMP_UPPER: begin
            next_rdata = upper_view(temp_sample);
         end
         tdo_pkg::ADDR_TEMP_LOWER: begin
            next_rdata = temp_sample_lower;
         end
         tdo_pkg::ADDR_DAC0_UPPER: begin
            next_rdata = upper_view(dac0_computed);
         end
         tdo_pkg::ADDR_DAC0_LOWER: begin
            next_rdata = lower_view(dac0_computed);
         end
         tdo_pkg::ADDR_DAC1_UPPER: begin
            next_rdata = upper_view(dac1_computed);
         end
         tdo_pkg::ADDR_DAC1_LOWER: begin
            next_rdata = lower_view(dac1_computed);
         end
         tdo_pkg::ADDR_TEMP_STATUS: begin
            next_rdata = (sensor_ready && seen_sample) ?
                         tdo_pkg::STATUS_READY : tdo_pkg::STATUS_BUSY;
         end
         tdo_pkg::ADDR_OVR_SELECT: begin
            next_rdata = {6'h00, override_select_reg};
         end
         tdo_pkg::ADDR_SENS_OVR_UPPER: begin
            next_rdata = upper_view(sensor_override_word);
         end
         tdo_pkg::ADDR_SENS_OVR_LOWER: begin
            next_rdata = lower_view(sensor_override_word);
         end
         tdo_pkg::ADDR_DAC0_OVR_UPPER: begin
            next_rdata = upper_view(dac0_override_word);
         end
         tdo_pkg::ADDR_DAC0_OVR_LOWER: begin
            next_rdata = lower_view(dac0_override_word);
         end
         tdo_pkg::ADDR_DAC1_OVR_UPPER: begin
            next_rdata = upper_view(dac1_override_word);
         end
         tdo_pkg::ADDR_DAC1_OVR_LOWER: begin
            next_rdata = lower_view(dac1_override_word);
         end
         tdo_pkg::ADDR_ACCESS_CTRL: begin
            next_rdata = privilege_level_two ?
                         tdo_pkg::ACC_LEVEL_TWO :
                         tdo_pkg::ACC_LEVEL_ZERO;
         end
         default: begin
            next_rdata = tdo_pkg::UNMAPPED_DATA;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= tdo_pkg::BYTE_RESET;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // converter paths
   // ------------------------------------------------------------------
   tdo_chan_path #(
      .W(W)
   ) u_chan0 (
      .clk(clk),
      .nrst(nrst),
      .alu_skip_flag(alu_skip_flag[0]),
      .stored_constant_level(stored_constant_level0),
      .computed_word(dac0_computed),
      .override_word(dac0_override_word),
      .converter_override_select(converter_override_select),
      .dac_word(dac0_word)
   );

   tdo_chan_path #(
      .W(W)
   ) u_chan1 (
      .clk(clk),
      .nrst(nrst),
      .alu_skip_flag(alu_skip_flag[1]),
      .stored_constant_level(stored_constant_level1),
      .computed_word(dac1_computed),
      .override_word(dac1_override_word),
      .converter_override_select(converter_override_select),
      .dac_word(dac1_word)
   );

endmodule : tdo_path_ctrl

// ---- verilog/tdo_pkg.sv ----
// package for the DAC signal-path override block: offsets, fields, codes
// assumes byte-wide register access from an external serial-link engine
package tdo_pkg;

   // ------
   // widths
   // ------
   localparam int unsigned WORD_W = 12;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned NIB_W = 4;

   // ------
   // register offsets
   // ------
   localparam logic [7:0] ADDR_TEMP_UPPER = 8'h00;
   localparam logic [7:0] ADDR_TEMP_LOWER = 8'h01;
   localparam logic [7:0] ADDR_DAC0_UPPER = 8'h02;
   localparam logic [7:0] ADDR_DAC0_LOWER = 8'h03;
   localparam logic [7:0] ADDR_DAC1_UPPER = 8'h04;
   localparam logic [7:0] ADDR_DAC1_LOWER = 8'h05;
   localparam logic [7:0] ADDR_TEMP_STATUS = 8'h07;
   localparam logic [7:0] ADDR_OVR_SELECT = 8'h08;
   localparam logic [7:0] ADDR_SENS_OVR_UPPER = 8'h09;
   localparam logic [7:0] ADDR_SENS_OVR_LOWER = 8'h0A;
   localparam logic [7:0] ADDR_DAC0_OVR_UPPER = 8'h0B;
   localparam logic [7:0] ADDR_DAC0_OVR_LOWER = 8'h0C;
   localparam logic [7:0] ADDR_DAC1_OVR_UPPER = 8'h0D;
   localparam logic [7:0] ADDR_DAC1_OVR_LOWER = 8'h0E;
   localparam logic [7:0] ADDR_ACCESS_CTRL = 8'h0F;

   // ------
   // fields, codes and reset values
   // ------
   localparam int unsigned SEL_SENSOR_BIT = 0;
   localparam int unsigned SEL_DAC_BIT = 1;
   localparam logic [7:0] KEY_FIRST = 8'hCD;
   localparam logic [7:0] KEY_SECOND = 8'hF0;
   localparam logic [7:0] ACC_LEVEL_ZERO = 8'h00;
   localparam logic [7:0] ACC_LEVEL_TWO = 8'h03;
   localparam logic [7:0] STATUS_READY = 8'h00;
   localparam logic [7:0] STATUS_BUSY = 8'hFF;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   localparam logic [11:0] WORD_RESET = 12'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] NIB_RESET = 4'h0;
   localparam logic [1:0] SEL_RESET = 2'h0;

   // ------
   // timing
   // ------
   localparam real CLK_MHZ = 200.0;
   localparam real SAMPLE_MS = 25.0;

   // access level sequencer
   typedef enum logic [2:0] {
      TDO_ACC_ZERO = 3'b001,
      TDO_ACC_KEYED = 3'b010,
      TDO_ACC_TWO = 3'b100
   } tdo_acc_t;

endpackage : tdo_pkg
